// ### dual_serial_control_port_defines.vh
`ifndef DUAL_SERIAL_CONTROL_PORT_DEFINES_VH
`define DUAL_SERIAL_CONTROL_PORT_DEFINES_VH

// ----------------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------------
`define I2C_SLAVE_ADDR 7'h18
`define I2C_GCALL_ADDR 7'h00
`define SYNC_IDLE 5'h1B

// ----------------------------------------------------------------------------
// Register space
// ----------------------------------------------------------------------------
`define PAGE_SEL_REG 7'h00
`define PAGE_RESET 8'h00
`define GCALL_EN_PAGE 8'h00
`define GCALL_EN_REG 7'h22
`define GCALL_EN_BIT 5
`define GCALL_EN_RESET 1'b0
`define LAST_REG 7'h7F
`define BUF_PAGE 8'hFC
`define BUF_REG_A 7'h01
`define BUF_REG_B 7'h02

// ----------------------------------------------------------------------------
// Bit counts
// ----------------------------------------------------------------------------
`define I2C_BYTE_BITS 4'h8
`define SPI_LAST_BIT 3'h7

`endif

// ### dual_serial_sync.v
`default_nettype none

module dual_serial_sync #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   // -------------------------------------------------------------------------
   // Two-flop synchronisers
   // -------------------------------------------------------------------------
   // Each bit resets to its line's idle level so that no edge is faked after reset.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge ref_clk_i) begin
            if (rst_i) begin
               meta <= IDLE[g];
               stable <= IDLE[g];
            end else begin
               meta <= async_i[g];
               stable <= meta;
            end
         end
         assign sync_o[g] = stable;
      end
   endgenerate

endmodule // dual_serial_sync

`default_nettype wire

// ### dual_serial_addr_step.v
`default_nettype none
`include "dual_serial_control_port_defines.vh"

module dual_serial_addr_step (
   input wire [7:0] page_i,
   input wire [6:0] addr_i,
   output reg [6:0] next_addr_o
);

   // -------------------------------------------------------------------------
   // Next register address for auto-increment
   // -------------------------------------------------------------------------
   always @* begin
      if (page_i == `BUF_PAGE && addr_i == `BUF_REG_A) begin
         next_addr_o = `BUF_REG_B;
      end else if (page_i == `BUF_PAGE && addr_i == `BUF_REG_B) begin
         next_addr_o = `BUF_REG_A;
      end else if (addr_i == `LAST_REG) begin
         next_addr_o = `LAST_REG;
      end else begin
         next_addr_o = addr_i + 7'h01;
      end
   end

endmodule // dual_serial_addr_step

`default_nettype wire

// ### dual_serial_control_port.v
`default_nettype none
`include "dual_serial_control_port_defines.vh"

module dual_serial_control_port (
   input wire ref_clk_i,
   input wire rst_i,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   input wire sclk_i,
   input wire ss_n_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_o,
   output reg [7:0] reg_page_o,
   output reg [6:0] reg_addr_o,
   output reg [7:0] reg_wdata_o,
   output reg reg_wr_o,
   output reg reg_rd_o,
   input wire [7:0] reg_rdata_i
);

   // -------------------------------------------------------------------------
   // I2C states
   // -------------------------------------------------------------------------
   localparam [2:0] I_IDLE = 3'h0;
   localparam [2:0] I_RX = 3'h1;
   localparam [2:0] I_ACK = 3'h2;
   localparam [2:0] I_TX = 3'h3;
   localparam [2:0] I_MACK = 3'h4;
   localparam [2:0] I_WAIT = 3'h5;

   localparam [1:0] B_ADDR = 2'h0;
   localparam [1:0] B_PTR = 2'h1;
   localparam [1:0] B_DATA = 2'h2;

   // -------------------------------------------------------------------------
   // Input synchronisation and edges
   // -------------------------------------------------------------------------
   wire [4:0] synced;
   wire scl;
   wire sda;
   wire sclk;
   wire ss_n;
   wire mosi;
   reg scl_q;
   reg sda_q;
   reg sclk_q;
   reg ss_n_q;

   dual_serial_sync #(.WIDTH(5), .IDLE(`SYNC_IDLE)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i({mosi_i, ss_n_i, sclk_i, sda_i, scl_i}),
      .sync_o(synced)
   );

   assign scl = synced[0];
   assign sda = synced[1];
   assign sclk = synced[2];
   assign ss_n = synced[3];
   assign mosi = synced[4];

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sclk_q <= 1'b0;
         ss_n_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         sclk_q <= sclk;
         ss_n_q <= ss_n;
      end
   end

   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire i_start = scl & scl_q & sda_q & ~sda;
   wire i_stop = scl & scl_q & ~sda_q & sda;
   wire sclk_rise = sclk & ~sclk_q;
   wire sclk_fall = ~sclk & sclk_q;
   wire ss_fall = ~ss_n & ss_n_q;

   // -------------------------------------------------------------------------
   // Shared state
   // -------------------------------------------------------------------------
   reg gcall_en;
   reg [7:0] rbuf;

   reg [2:0] i_state;
   reg [3:0] i_bits;
   reg [7:0] i_shift;
   reg [1:0] i_byte;
   reg i_rw;
   reg [6:0] i_ptr;
   reg i_wr_req;
   reg [6:0] i_wr_addr;
   reg [7:0] i_wr_data;
   reg i_rd_req;
   reg [6:0] i_rd_addr;
   wire [6:0] i_nxt;

   reg [2:0] s_bits;
   reg [7:0] s_shift;
   reg [7:0] s_tx;
   reg s_done;
   reg s_rw;
   reg [6:0] s_addr;
   reg s_wr_req;
   reg [6:0] s_wr_addr;
   reg [7:0] s_wr_data;
   reg s_rd_req;
   reg [6:0] s_rd_addr;
   wire [6:0] s_nxt;

   wire [7:0] i_byte_in = i_shift;
   wire [7:0] s_byte_in = {s_shift[6:0], mosi};
   wire addr_hit = (i_byte_in[7:1] == `I2C_SLAVE_ADDR);
   wire gcall_hit = (i_byte_in[7:1] == `I2C_GCALL_ADDR) & gcall_en & ~i_byte_in[0];

   dual_serial_addr_step u_i2c_step (
      .page_i(reg_page_o),
      .addr_i(i_ptr),
      .next_addr_o(i_nxt)
   );

   dual_serial_addr_step u_spi_step (
      .page_i(reg_page_o),
      .addr_i(s_addr),
      .next_addr_o(s_nxt)
   );

   // -------------------------------------------------------------------------
   // I2C slave engine
   // -------------------------------------------------------------------------
   // SDA is only ever pulled low; the output value is a constant zero.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         i_state <= I_IDLE;
         i_bits <= 4'h0;
         i_shift <= 8'h00;
         i_byte <= B_ADDR;
         i_rw <= 1'b0;
         i_ptr <= 7'h00;
         i_wr_req <= 1'b0;
         i_wr_addr <= 7'h00;
         i_wr_data <= 8'h00;
         i_rd_req <= 1'b0;
         i_rd_addr <= 7'h00;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         i_wr_req <= 1'b0;
         i_rd_req <= 1'b0;
         sda_o <= 1'b0;
         if (i_start) begin
            i_state <= I_RX;
            i_bits <= 4'h0;
            i_byte <= B_ADDR;
            sda_oe_o <= 1'b0;
         end else if (i_stop) begin
            i_state <= I_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (i_state)
               I_RX: begin
                  if (scl_rise) begin
                     i_shift <= {i_shift[6:0], sda};
                     i_bits <= i_bits + 4'h1;
                  end else if (scl_fall && i_bits == `I2C_BYTE_BITS) begin
                     i_bits <= 4'h0;
                     case (i_byte)
                        B_ADDR: begin
                           if (addr_hit || gcall_hit) begin
                              sda_oe_o <= 1'b1;
                              i_rw <= i_byte_in[0];
                              i_byte <= B_PTR;
                              i_state <= I_ACK;
                              i_rd_req <= i_byte_in[0];
                              i_rd_addr <= i_ptr;
                           end else begin
                              i_state <= I_WAIT;
                           end
                        end
                        B_PTR: begin
                           i_ptr <= i_byte_in[6:0];
                           i_byte <= B_DATA;
                           sda_oe_o <= 1'b1;
                           i_state <= I_ACK;
                        end
                        default: begin
                           i_wr_req <= 1'b1;
                           i_wr_addr <= i_ptr;
                           i_wr_data <= i_byte_in;
                           i_ptr <= i_nxt;
                           sda_oe_o <= 1'b1;
                           i_state <= I_ACK;
                        end
                     endcase
                  end
               end
               I_ACK: begin
                  if (scl_fall) begin
                     if (i_rw) begin
                        i_shift <= rbuf;
                        sda_oe_o <= ~rbuf[7];
                        i_bits <= 4'h1;
                        i_state <= I_TX;
                     end else begin
                        sda_oe_o <= 1'b0;
                        i_state <= I_RX;
                     end
                  end
               end
               I_TX: begin
                  if (scl_fall) begin
                     if (i_bits == `I2C_BYTE_BITS) begin
                        sda_oe_o <= 1'b0;
                        i_bits <= 4'h0;
                        i_state <= I_MACK;
                     end else begin
                        sda_oe_o <= ~i_shift[6];
                        i_shift <= {i_shift[6:0], 1'b0};
                        i_bits <= i_bits + 4'h1;
                     end
                  end
               end
               I_MACK: begin
                  if (scl_rise) begin
                     if (!sda) begin
                        i_ptr <= i_nxt;
                        i_rd_addr <= i_nxt;
                        i_rd_req <= 1'b1;
                        i_state <= I_ACK;
                     end else begin
                        i_state <= I_WAIT;
                     end
                  end
               end
               I_WAIT: begin
                  sda_oe_o <= 1'b0;
               end
               default: begin
                  i_state <= I_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // SPI slave engine
   // -------------------------------------------------------------------------
   // MISO is driven only while the synchronised select is low; it is released one cycle after that select rises.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_bits <= 3'h0;
         s_shift <= 8'h00;
         s_tx <= 8'h00;
         s_done <= 1'b0;
         s_rw <= 1'b0;
         s_addr <= 7'h00;
         s_wr_req <= 1'b0;
         s_wr_addr <= 7'h00;
         s_wr_data <= 8'h00;
         s_rd_req <= 1'b0;
         s_rd_addr <= 7'h00;
         miso_o <= 1'b0;
         miso_oe_o <= 1'b0;
      end else begin
         s_wr_req <= 1'b0;
         s_rd_req <= 1'b0;
         miso_oe_o <= ~ss_n;
         if (ss_n || ss_fall) begin
            s_bits <= 3'h0;
            s_done <= 1'b0;
            s_tx <= 8'h00;
            miso_o <= 1'b0;
         end else begin
            if (sclk_fall) begin
               s_shift <= s_byte_in;
               s_bits <= s_bits + 3'h1;
               if (s_bits == `SPI_LAST_BIT) begin
                  if (!s_done) begin
                     s_done <= 1'b1;
                     s_addr <= s_byte_in[7:1];
                     s_rw <= s_byte_in[0];
                     s_rd_req <= s_byte_in[0];
                     s_rd_addr <= s_byte_in[7:1];
                  end else if (!s_rw) begin
                     s_wr_req <= 1'b1;
                     s_wr_addr <= s_addr;
                     s_wr_data <= s_byte_in;
                     s_addr <= s_nxt;
                  end else begin
                     s_addr <= s_nxt;
                     s_rd_req <= 1'b1;
                     s_rd_addr <= s_nxt;
                  end
               end
            end
            if (sclk_rise) begin
               if (s_done && s_rw && s_bits == 3'h0) begin
                  miso_o <= rbuf[7];
                  s_tx <= {rbuf[6:0], 1'b0};
               end else if (s_done && s_rw) begin
                  miso_o <= s_tx[7];
                  s_tx <= {s_tx[6:0], 1'b0};
               end else begin
                  miso_o <= 1'b0;
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Register access stage
   // -------------------------------------------------------------------------
   // A write beats a read in a same-cycle clash, then I2C beats SPI; the host is expected to use one port at once.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_page_o <= `PAGE_RESET;
         reg_addr_o <= 7'h00;
         reg_wdata_o <= 8'h00;
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         gcall_en <= `GCALL_EN_RESET;
         rbuf <= 8'h00;
      end else begin
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         if (reg_rd_o) begin
            rbuf <= (reg_addr_o == `PAGE_SEL_REG) ? reg_page_o : reg_rdata_i;
         end
         if (i_wr_req || s_wr_req) begin
            reg_wr_o <= 1'b1;
            reg_addr_o <= i_wr_req ? i_wr_addr : s_wr_addr;
            reg_wdata_o <= i_wr_req ? i_wr_data : s_wr_data;
         end else if (i_rd_req || s_rd_req) begin
            reg_rd_o <= 1'b1;
            reg_addr_o <= i_rd_req ? i_rd_addr : s_rd_addr;
         end
         if (reg_wr_o && reg_addr_o == `PAGE_SEL_REG) begin
            reg_page_o <= reg_wdata_o;
         end
         if (reg_wr_o && reg_page_o == `GCALL_EN_PAGE && reg_addr_o == `GCALL_EN_REG) begin
            gcall_en <= reg_wdata_o[`GCALL_EN_BIT];
         end
      end
   end

endmodule // dual_serial_control_port

`default_nettype wire

// ### dual_serial_control_port_asserts.sv
`default_nettype none

module dual_serial_control_port_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic sclk_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic [7:0] reg_page_o,
   input wire logic [6:0] reg_addr_o,
   input wire logic [7:0] reg_wdata_o,
   input wire logic reg_wr_o,
   input wire logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Port checks
   // ----------------------------------------------------------------
   // The pins pass synchronisers, so windows are a few cycles wide.
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   od_low_only_a: assert property (sda_oe_o |-> !sda_o)
      else $error("data line driven high");
   ack_while_low_a: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("data drive began with clock high");
   sda_steady_high_a: assert property (scl_i [*8] |-> $stable(sda_oe_o))
      else $error("data drive moved with clock high");
   stop_releases_a: assert property ((scl_i && $rose(sda_i)) |-> ##[1:8] !sda_oe_o)
      else $error("data line held after stop");
   pulse_spacing_a: assert property (reg_wr_o |=> (!reg_wr_o && !reg_rd_o) [*8])
      else $error("register accesses too close");
   one_access_a: assert property (!(reg_wr_o && reg_rd_o))
      else $error("read and write in one cycle");
   page_load_a: assert property ((reg_wr_o && reg_addr_o == 7'h00) |=> reg_page_o == $past(reg_wdata_o))
      else $error("page not loaded");
   page_hold_a: assert property (!(reg_wr_o && reg_addr_o == 7'h00) |=> $stable(reg_page_o))
      else $error("page changed without write");
   select_idle_a: assert property (ss_n_i [*5] |-> !miso_oe_o)
      else $error("serial out driven while deselected");
   miso_quiet_a: assert property ((!sclk_i && !ss_n_i) [*8] |-> $stable(miso_o))
      else $error("serial out moved while clock low");
endmodule // dual_serial_control_port_asserts

bind dual_serial_control_port dual_serial_control_port_asserts chk_u (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .sclk_i(sclk_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
   .reg_page_o(reg_page_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
   .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i));

`default_nettype wire

// ### host_master_model.sv
`default_nettype none

module host_master_model (
   input wire logic ref_clk_i,
   input wire logic sda_line_i,
   input wire logic miso_line_i,
   output var logic scl_o,
   output var logic sda_pull_o,
   output var logic sclk_o,
   output var logic ss_n_o,
   output var logic mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Host side of both ports
   // ----------------------------------------------------------------
   // One bit takes 40 cycles, a 160 ns link clock period.
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic i2c_start();
      sda_pull_o = 1'b0;
      step(10);
      scl_o = 1'b1;
      step(10);
      sda_pull_o = 1'b1;
      step(10);
      scl_o = 1'b0;
      step(10);
   endtask
   task automatic i2c_stop();
      sda_pull_o = 1'b1;
      step(10);
      scl_o = 1'b1;
      step(10);
      sda_pull_o = 1'b0;
      step(20);
   endtask
   task automatic i2c_bit(input logic b, output logic r);
      sda_pull_o = ~b;
      step(10);
      scl_o = 1'b1;
      step(19);
      r = sda_line_i;
      step(1);
      scl_o = 1'b0;
      step(10);
   endtask
   task automatic i2c_wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
      i2c_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic i2c_rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) i2c_bit(1'b1, d[i]);
      i2c_bit(~ack, r);
   endtask
   task automatic spi_begin();
      ss_n_o = 1'b0;
      step(20);
   endtask
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b1;
         mosi_o = tx[i];
         step(20);
         rx[i] = miso_line_i;
         sclk_o = 1'b0;
         step(20);
      end
   endtask
   task automatic spi_end();
      ss_n_o = 1'b1;
      mosi_o = ~mosi_o;
      step(20);
   endtask
endmodule // host_master_model

`default_nettype wire

// ### test_dual_serial_control_port.sv
`default_nettype none

module test_dual_serial_control_port;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Wiring and storage
   // ----------------------------------------------------------------
   localparam int LIMIT = 50000;
   logic ref_clk_i, rst_i, scl, sda_pull, sda_line, sclk, ss_n, mosi, miso_line, miso_last_n;
   logic sda_o, sda_oe_o, miso_o, miso_oe_o, reg_wr_o, reg_rd_o;
   logic [7:0] reg_page_o, reg_wdata_o, reg_rdata_i;
   logic [6:0] reg_addr_o;
   logic [7:0] mem [0:32767];
   int err_total, checked, cycles;
   // A pull-up holds the data line high unless somebody pulls it low.
   assign sda_line = !((sda_oe_o && !sda_o) || sda_pull);
   assign miso_line = miso_oe_o ? miso_o : miso_last_n;
   assign reg_rdata_i = mem[{reg_page_o, reg_addr_o}];
   dual_serial_control_port dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso_o),
      .miso_oe_o(miso_oe_o), .reg_page_o(reg_page_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
      .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i));
   host_master_model host_u (.ref_clk_i(ref_clk_i), .sda_line_i(sda_line), .miso_line_i(miso_line),
      .scl_o(scl), .sda_pull_o(sda_pull), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      if (reg_wr_o) mem[{reg_page_o, reg_addr_o}] <= reg_wdata_o;
      if (miso_oe_o) miso_last_n <= ~miso_o;
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         err_total = err_total + 1;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] init_val(input logic [14:0] a);
      return a[7:0] ^ a[14:7];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_i2c_write();
      logic ack;
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h30, ack);
      check(8'(ack), 8'h01);
      host_u.i2c_wr_byte(8'h7E, ack);
      host_u.i2c_wr_byte(8'hC3, ack);
      host_u.i2c_wr_byte(8'h96, ack);
      host_u.i2c_wr_byte(8'h69, ack);
      check(8'(ack), 8'h01);
      host_u.i2c_stop();
      check(mem[{8'h00, 7'h7E}], 8'hC3);
      check(mem[{8'h00, 7'h7F}], 8'h69);
      check(8'(sda_oe_o), 8'h00);
      $display("test i2c_write done");
   endtask
   task automatic t_i2c_read();
      logic ack;
      logic [7:0] d;
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h30, ack);
      host_u.i2c_wr_byte(8'h7E, ack);
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h31, ack);
      check(8'(ack), 8'h01);
      host_u.i2c_rd_byte(1'b1, d);
      check(d, 8'hC3);
      host_u.i2c_rd_byte(1'b1, d);
      check(d, 8'h69);
      host_u.i2c_rd_byte(1'b0, d);
      check(d, 8'h69);
      host_u.i2c_stop();
      check(8'(sda_oe_o), 8'h00);
      $display("test i2c_read done");
   endtask
   task automatic t_i2c_address();
      logic ack;
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h32, ack);
      check(8'(ack), 8'h00);
      host_u.i2c_stop();
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h00, ack);
      check(8'(ack), 8'h00);
      host_u.i2c_stop();
      // Only the enable bit is set; the other bits are written as zero.
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h30, ack);
      host_u.i2c_wr_byte(8'h22, ack);
      host_u.i2c_wr_byte(8'h20, ack);
      host_u.i2c_stop();
      host_u.i2c_start();
      host_u.i2c_wr_byte(8'h00, ack);
      check(8'(ack), 8'h01);
      host_u.i2c_stop();
      $display("test i2c_address done");
   endtask
   task automatic t_spi_rw();
      logic [7:0] rx;
      host_u.spi_begin();
      host_u.spi_byte(8'h0A, rx);
      host_u.spi_byte(8'h3C, rx);
      host_u.spi_end();
      check(mem[{8'h00, 7'h05}], 8'h3C);
      host_u.spi_begin();
      host_u.spi_byte(8'h0B, rx);
      host_u.spi_byte(8'h00, rx);
      host_u.spi_end();
      check(rx, 8'h3C);
      host_u.spi_begin();
      host_u.spi_byte(8'hFE, rx);
      host_u.spi_byte(8'hA1, rx);
      host_u.spi_byte(8'hB2, rx);
      host_u.spi_end();
      check(mem[{8'h00, 7'h7F}], 8'hB2);
      check(reg_page_o, 8'h00);
      $display("test spi_rw done");
   endtask
   task automatic t_spi_buffer();
      logic [7:0] rx;
      host_u.spi_begin();
      host_u.spi_byte(8'h00, rx);
      host_u.spi_byte(8'hFC, rx);
      host_u.spi_end();
      check(reg_page_o, 8'hFC);
      host_u.spi_begin();
      host_u.spi_byte(8'h01, rx);
      host_u.spi_byte(8'h00, rx);
      host_u.spi_end();
      check(rx, 8'hFC);
      host_u.spi_begin();
      host_u.spi_byte(8'h03, rx);
      for (int k = 0; k < 4; k++) begin
         host_u.spi_byte(8'h00, rx);
         check(rx, init_val({8'hFC, (k % 2 == 0) ? 7'h01 : 7'h02}));
      end
      host_u.spi_end();
      $display("test spi_buffer done");
   endtask
   initial begin
      err_total = 0;
      checked = 0;
      cycles = 0;
      miso_last_n = 1'b1;
      rst_i = 1'b1;
      for (int i = 0; i < 32768; i++) mem[i] = init_val(15'(i));
      repeat (5) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      check(reg_page_o, 8'h00);
      repeat (6) @(posedge ref_clk_i);
      #1;
      t_i2c_write();
      t_i2c_read();
      t_i2c_address();
      t_spi_rw();
      t_spi_buffer();
      finish_test();
   end
endmodule // test_dual_serial_control_port

`default_nettype wire
